// File: logic/pdv_pkg.sv
// package for the port phy vendor control bank
// assumes an 8-bit register port with byte offsets as printed
package pdv_pkg;
  localparam logic [7:0] RX_CTRL_ADDR   = 8'h96;
  localparam logic [7:0] RX_STAT_ADDR   = 8'h97;
  localparam logic [7:0] DISCH_ADDR     = 8'h98;
  localparam logic [7:0] OTEMP_ADDR     = 8'h99;
  localparam logic [7:0] TMR_LO_ADDR    = 8'ha0;
  localparam logic [7:0] TMR_HI_ADDR    = 8'ha1;
  localparam logic [7:0] RESET_VALUE    = 8'h00;
  // field positions
  localparam int FAST_SWAP_BIT   = 3;
  localparam int OVERRIDE_BIT    = 2;
  localparam int PREAMBLE_BIT    = 3;
  localparam int CRC_OK_BIT      = 2;
  localparam int EOP_BIT         = 1;
  localparam int SOP_BIT         = 0;
  localparam int CABLE_DIS_BIT   = 1;
  localparam int BUS_DIS_BIT     = 0;
  localparam int OT_LIVE_BIT     = 4;
  localparam int OT_EN_BIT       = 0;
  // threshold select codes
  localparam logic [1:0] THR_SINK    = 2'h0;
  localparam logic [1:0] THR_SOURCE  = 2'h1;
  localparam logic [1:0] THR_NEUTRAL = 2'h2;
  localparam logic [1:0] THR_MIXED   = 2'h3;
  // timer tick: one count per 1000 us at 200 MHz
  localparam int TICK_US      = 1000;
  localparam int CLK_MHZ      = 200;
  localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
endpackage : pdv_pkg

// File: logic/pdv_countdown.sv
// 16-bit millisecond countdown with prescaler
// assumes load is a one-cycle pulse from the register bank
`timescale 1ns/1ps
module pdv_countdown #(
  parameter int TICK_CYCLES = pdv_pkg::TICK_CYCLES
)(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // load
  input  wire logic        load,
  input  wire logic [15:0] load_value,
  // state
  output logic             running,
  output logic             expire_pulse,
  output logic [15:0]      count
);
  typedef struct packed {
    logic [15:0] count;
    logic [31:0] pre;
    logic        expire;
  } pdv_cnt_state_type;

  pdv_cnt_state_type state;
  pdv_cnt_state_type next_state;

  // prescale to a 1 ms tick, then step the count down
  always_comb
  begin
    next_state = state;
    next_state.expire = 1'b0;
    if (load)
    begin
      next_state.count = load_value;
      next_state.pre = 32'h0;
    end
    else if (state.count != 16'h0)
    begin
      if (state.pre == 32'(TICK_CYCLES - 1))
      begin
        next_state.pre = 32'h0;
        next_state.count = state.count - 16'h1;
        if (state.count == 16'h1)
          next_state.expire = 1'b1;
      end
      else
        next_state.pre = state.pre + 32'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign running = (state.count != 16'h0);
  assign expire_pulse = state.expire;
  assign count = state.count;

  // zero load stops the timer with no expiry
  zero_stops_a: assert property (@(posedge core_clk) disable iff (rst)
    load && load_value == 16'h0 |=> !running && !expire_pulse)
    else $error("zero load did not stop timer");
  nonzero_runs_a: assert property (@(posedge core_clk) disable iff (rst)
    load && load_value != 16'h0 |=> running && count == $past(load_value))
    else $error("nonzero load did not start timer");
  expire_at_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    expire_pulse |-> count == 16'h0 && $past(count) == 16'h1)
    else $error("expiry not at zero");
  step_rate_a: assert property (@(posedge core_clk) disable iff (rst)
    !load && $past(!load) && count != $past(count) |->
    $past(state.pre) == 32'(TICK_CYCLES - 1))
    else $error("count moved off tick");
  expire_c: cover property (@(posedge core_clk) disable iff (rst)
    expire_pulse);
endmodule : pdv_countdown

// File: logic/pdv_bank.sv
// vendor control and status register bank of a pd port phy
// assumes a synchronous byte register port from the serial management
// slave: one-cycle write strobe, read data returned from flip-flops
`timescale 1ns/1ps
module pdv_bank #(
  parameter int TICK_CYCLES = pdv_pkg::TICK_CYCLES
)(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // receiver events and link signals
  input  wire logic       rx_preamble,
  input  wire logic       rx_crc_ok,
  input  wire logic       rx_eop,
  input  wire logic       rx_sop,
  input  wire logic       fast_swap_signal,
  input  wire logic       power_role_source,
  output logic            fast_swap_detected,
  output logic      [1:0] rx_threshold_high_sel,
  output logic      [1:0] rx_threshold_low_sel,
  // discharge
  input  wire logic       cable_discharge_request,
  input  wire logic       bus_discharge_request,
  output logic            cable_discharge_on,
  output logic            bus_discharge_on,
  // temperature
  input  wire logic       overtemp_sensor,
  output logic            overtemp_shutdown,
  // timer
  output logic            slow_timer_expired,
  output logic            slow_timer_running
);
  typedef struct packed {
    logic       fast_swap_detect_enable;
    logic       rx_threshold_override;
    logic [1:0] rx_threshold_select;
    logic [3:0] rx_status;
    logic       cable_power_discharge_off;
    logic       bus_power_discharge_off;
    logic       overtemp_shutdown_enable;
    logic       overtemp_live_state;
    logic [7:0] slow_timer_low;
    logic [7:0] slow_timer_high;
    logic       slow_timer_expired;
    logic       fast_swap_detected;
    logic [1:0] thr_high;
    logic [1:0] thr_low;
    logic       cable_on;
    logic       bus_on;
    logic       shutdown;
    logic [7:0] rdata;
  } pdv_bank_state_type;

  pdv_bank_state_type state;
  pdv_bank_state_type next_state;
  logic        timer_load;
  logic        timer_expire;
  logic        timer_running;
  logic [15:0] timer_count;

  // high byte write commits both bytes to the counter
  assign timer_load = reg_write && reg_addr == pdv_pkg::TMR_HI_ADDR;

  pdv_countdown #(
    .TICK_CYCLES (TICK_CYCLES)
  ) pdv_countdown_inst (
    .core_clk     (core_clk),
    .rst          (rst),
    .load         (timer_load),
    .load_value   ({reg_wdata, state.slow_timer_low}),
    .running      (timer_running),
    .expire_pulse (timer_expire),
    .count        (timer_count)
  );

  // register writes, status capture and output decode
  always_comb
  begin
    next_state = state;
    if (reg_write)
    begin
      case (reg_addr)
        pdv_pkg::RX_CTRL_ADDR:
        begin
          // upper nibble is reserved and dropped
          next_state.fast_swap_detect_enable =
            reg_wdata[pdv_pkg::FAST_SWAP_BIT];
          next_state.rx_threshold_override = reg_wdata[pdv_pkg::OVERRIDE_BIT];
          next_state.rx_threshold_select = reg_wdata[1:0];
        end
        pdv_pkg::DISCH_ADDR:
        begin
          next_state.cable_power_discharge_off =
            reg_wdata[pdv_pkg::CABLE_DIS_BIT];
          next_state.bus_power_discharge_off = reg_wdata[pdv_pkg::BUS_DIS_BIT];
        end
        pdv_pkg::OTEMP_ADDR:
          next_state.overtemp_shutdown_enable = reg_wdata[pdv_pkg::OT_EN_BIT];
        pdv_pkg::TMR_LO_ADDR:
          next_state.slow_timer_low = reg_wdata;
        pdv_pkg::TMR_HI_ADDR:
          next_state.slow_timer_high = reg_wdata;
        default:
          next_state.rdata = state.rdata;
      endcase
    end
    // receiver status follows the live receiver events
    next_state.rx_status = {rx_preamble, rx_crc_ok, rx_eop, rx_sop};
    // raw sensor only reported while the function is enabled
    next_state.overtemp_live_state =
      state.overtemp_shutdown_enable & overtemp_sensor;
    next_state.shutdown = state.overtemp_shutdown_enable & overtemp_sensor;
    // expiry sticks until a new load; a zero load never sets it
    if (timer_expire)
      next_state.slow_timer_expired = 1'b1;
    else if (timer_load)
      next_state.slow_timer_expired = 1'b0;
    next_state.fast_swap_detected =
      state.fast_swap_detect_enable & fast_swap_signal;
    // threshold pair: override selects the field, else follow power role
    if (state.rx_threshold_override)
    begin
      case (state.rx_threshold_select)
        pdv_pkg::THR_SINK:
        begin
          next_state.thr_high = pdv_pkg::THR_SINK;
          next_state.thr_low = pdv_pkg::THR_SINK;
        end
        pdv_pkg::THR_SOURCE:
        begin
          next_state.thr_high = pdv_pkg::THR_SOURCE;
          next_state.thr_low = pdv_pkg::THR_SOURCE;
        end
        pdv_pkg::THR_NEUTRAL:
        begin
          next_state.thr_high = pdv_pkg::THR_NEUTRAL;
          next_state.thr_low = pdv_pkg::THR_NEUTRAL;
        end
        default:
        begin
          next_state.thr_high = pdv_pkg::THR_SINK;
          next_state.thr_low = pdv_pkg::THR_SOURCE;
        end
      endcase
    end
    else
    begin
      next_state.thr_high = power_role_source ? pdv_pkg::THR_SOURCE
                                              : pdv_pkg::THR_SINK;
      next_state.thr_low = next_state.thr_high;
    end
    next_state.cable_on =
      cable_discharge_request & ~state.cable_power_discharge_off;
    next_state.bus_on =
      bus_discharge_request & ~state.bus_power_discharge_off;
    // read data: reserved bits read zero, unmapped reads zero
    next_state.rdata = 8'h00;
    if (reg_read)
    begin
      case (reg_addr)
        pdv_pkg::RX_CTRL_ADDR:
          next_state.rdata = {4'h0, state.fast_swap_detect_enable,
            state.rx_threshold_override, state.rx_threshold_select};
        pdv_pkg::RX_STAT_ADDR:
          next_state.rdata = {4'h0, state.rx_status};
        pdv_pkg::DISCH_ADDR:
          next_state.rdata = {6'h00, state.cable_power_discharge_off,
            state.bus_power_discharge_off};
        pdv_pkg::OTEMP_ADDR:
          next_state.rdata = {3'h0, state.overtemp_live_state, 3'h0,
            state.overtemp_shutdown_enable};
        pdv_pkg::TMR_LO_ADDR:
          next_state.rdata = state.slow_timer_low;
        pdv_pkg::TMR_HI_ADDR:
          next_state.rdata = state.slow_timer_high;
        default:
          next_state.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign reg_rdata = state.rdata;
  assign fast_swap_detected = state.fast_swap_detected;
  assign rx_threshold_high_sel = state.thr_high;
  assign rx_threshold_low_sel = state.thr_low;
  assign cable_discharge_on = state.cable_on;
  assign bus_discharge_on = state.bus_on;
  assign overtemp_shutdown = state.shutdown;
  assign slow_timer_expired = state.slow_timer_expired;
  assign slow_timer_running = timer_running;

  // checks
  fast_swap_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    fast_swap_detected |-> $past(state.fast_swap_detect_enable))
    else $error("fast swap seen while disabled");
  role_thresh_a: assert property (@(posedge core_clk) disable iff (rst)
    !$past(state.rx_threshold_override) |->
    rx_threshold_high_sel == ($past(power_role_source) ?
      pdv_pkg::THR_SOURCE : pdv_pkg::THR_SINK))
    else $error("threshold not from power role");
  mixed_thresh_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(state.rx_threshold_override) &&
    $past(state.rx_threshold_select) == pdv_pkg::THR_MIXED |->
    rx_threshold_high_sel == pdv_pkg::THR_SINK &&
    rx_threshold_low_sel == pdv_pkg::THR_SOURCE)
    else $error("mixed threshold pair wrong");
  // status read shows the receiver events of two cycles before the answer
  rx_status_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_read && reg_addr == pdv_pkg::RX_STAT_ADDR |=>
    reg_rdata == {4'h0, $past(rx_preamble, 2), $past(rx_crc_ok, 2),
      $past(rx_eop, 2), $past(rx_sop, 2)})
    else $error("receive status lost");
  cable_dis_a: assert property (@(posedge core_clk) disable iff (rst)
    cable_discharge_on |-> !$past(state.cable_power_discharge_off))
    else $error("cable discharge while disabled");
  bus_dis_a: assert property (@(posedge core_clk) disable iff (rst)
    bus_discharge_request && !state.bus_power_discharge_off |=>
    bus_discharge_on)
    else $error("bus discharge missing");
  shutdown_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    overtemp_shutdown |-> $past(state.overtemp_shutdown_enable))
    else $error("shutdown while disabled");
  // one idle cycle between write and read, as the host leaves it
  low_byte_read_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_write && reg_addr == pdv_pkg::TMR_LO_ADDR ##1 !reg_write ##1
    reg_read && reg_addr == pdv_pkg::TMR_LO_ADDR && !reg_write |=>
    reg_rdata == $past(reg_wdata, 3))
    else $error("low byte readback wrong");
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(reg_read) && $past(reg_addr) == pdv_pkg::OTEMP_ADDR |->
    reg_rdata[7:5] == 3'h0 && reg_rdata[3:1] == 3'h0)
    else $error("reserved bits nonzero");
  lo_only_no_load_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_write && reg_addr == pdv_pkg::TMR_LO_ADDR && !timer_running |=>
    !timer_running)
    else $error("low byte write loaded timer");
  // read data stands one cycle only, so a stale byte never looks valid
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data stood past its cycle");
  live_bit_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_read && reg_addr == pdv_pkg::OTEMP_ADDR |=>
    reg_rdata[pdv_pkg::OT_LIVE_BIT] == ($past(overtemp_sensor, 2) &&
      $past(state.overtemp_shutdown_enable, 2)))
    else $error("live sensor bit wrong");
  // expiry flag: set by the counter, cleared by a fresh load
  expiry_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    timer_expire |=> slow_timer_expired)
    else $error("expiry flag not set");
  load_clears_a: assert property (@(posedge core_clk) disable iff (rst)
    timer_load && !timer_expire |=> !slow_timer_expired)
    else $error("new load left expiry flag set");
  low_thresh_a: assert property (@(posedge core_clk) disable iff (rst)
    !$past(state.rx_threshold_override) |->
    rx_threshold_low_sel == ($past(power_role_source) ?
      pdv_pkg::THR_SOURCE : pdv_pkg::THR_SINK))
    else $error("low threshold not from power role");
  cable_on_a: assert property (@(posedge core_clk) disable iff (rst)
    cable_discharge_request && !state.cable_power_discharge_off |=>
    cable_discharge_on)
    else $error("cable discharge missing");
  fast_swap_on_a: assert property (@(posedge core_clk) disable iff (rst)
    state.fast_swap_detect_enable && fast_swap_signal |=>
    fast_swap_detected)
    else $error("fast swap signal missed");
  // scenario covers
  reload_c: cover property (@(posedge core_clk) disable iff (rst)
    timer_load && timer_running);
  expired_c: cover property (@(posedge core_clk) disable iff (rst)
    $rose(slow_timer_expired));
  override_c: cover property (@(posedge core_clk) disable iff (rst)
    state.rx_threshold_override && state.rx_threshold_select ==
    pdv_pkg::THR_NEUTRAL);
  shutdown_c: cover property (@(posedge core_clk) disable iff (rst)
    overtemp_shutdown);
endmodule : pdv_bank

// File: verif/pdv_host_model.sv
// host model: the port manager side of the byte register port
// assumes the bank takes a strobe on the rising edge; this side drives
// on the falling edge and runs one transfer at a time
`timescale 1ns/1ps
module pdv_host_model (
  // clock
  input  wire logic       core_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_write,
  output logic      [7:0] reg_wdata,
  output logic            reg_read,
  input  wire logic [7:0] reg_rdata
);
  // idle port at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    reg_read  = 1'b0;
  end

  // released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge core_clk);
    reg_write = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  // read data stands for exactly the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge core_clk);
    d        = reg_rdata;
    reg_read = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : pdv_host_model

// File: verif/pdv_bank_tb_top.sv
// testbench of the vendor control bank: a table of register cases,
// then hand-written checks of link outputs and the countdown
// assumes the host model owns the register port; the bench drives the rest
`timescale 1ns/1ps
`define CHK(act, exp) begin n_tests++; if ((act) !== (exp)) begin \
  errors++; $display("wrong value at %0t: got %h expected %h", \
  $time, (act), (exp)); end end
module pdv_bank_tb_top;
  localparam int TICK = 4; // short tick keeps the countdown inside the run
  logic       core_clk;
  logic       rst;
  logic [7:0] reg_addr;
  logic       reg_write;
  logic [7:0] reg_wdata;
  logic       reg_read;
  logic [7:0] reg_rdata;
  logic [7:0] rdv;
  logic [3:0] rx_ev;
  logic       fast_swap_signal;
  logic       power_role_source;
  logic       fast_swap_detected;
  logic [1:0] th_hi;
  logic [1:0] th_lo;
  logic [1:0] dreq;
  logic [1:0] dis_on;
  logic       overtemp_sensor;
  logic       overtemp_shutdown;
  logic       slow_timer_expired;
  logic       slow_timer_running;
  logic [1:0] eh;
  logic [1:0] el;
  int         errors;
  int         n_tests;
  int         n;
  // address, write data, expected read back
  logic [23:0] rows [9] = '{24'h96ff0f, 24'h97ff00, 24'h98ff03,
    24'h99ff01, 24'ha05a5a, 24'h9aff00, 24'h960000, 24'h980000,
    24'h990000};
  logic [7:0]  addrs [5] = '{8'h96, 8'h97, 8'h98, 8'h99, 8'ha0};

  pdv_bank #(.TICK_CYCLES(TICK)) pdv_bank_inst (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .rx_preamble(rx_ev[3]), .rx_crc_ok(rx_ev[2]),
    .rx_eop(rx_ev[1]), .rx_sop(rx_ev[0]),
    .fast_swap_signal(fast_swap_signal),
    .power_role_source(power_role_source),
    .fast_swap_detected(fast_swap_detected),
    .rx_threshold_high_sel(th_hi), .rx_threshold_low_sel(th_lo),
    .cable_discharge_request(dreq[1]), .bus_discharge_request(dreq[0]),
    .cable_discharge_on(dis_on[1]), .bus_discharge_on(dis_on[0]),
    .overtemp_sensor(overtemp_sensor),
    .overtemp_shutdown(overtemp_shutdown),
    .slow_timer_expired(slow_timer_expired),
    .slow_timer_running(slow_timer_running));

  pdv_host_model pdv_host_model_inst (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata));

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  task automatic settle(input int k);
    repeat (k) @(negedge core_clk);
  endtask : settle

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // watchdog: the whole sequence needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    core_clk = 1'b0; rst = 1'b1; rx_ev = 4'h0; dreq = 2'h0;
    fast_swap_signal = 1'b0; power_role_source = 1'b0;
    overtemp_sensor = 1'b0; errors = 0; n_tests = 0;
    settle(8);
    rst = 1'b0;
    foreach (addrs[i])
    begin
      pdv_host_model_inst.rd(addrs[i], rdv);
      `CHK(rdv, 8'h00)
    end
    `CHK({fast_swap_detected, dis_on, slow_timer_expired}, 4'h0)
    // ordinary register cases
    foreach (rows[i])
    begin
      pdv_host_model_inst.wr(rows[i][23:16], rows[i][15:8]);
      pdv_host_model_inst.rd(rows[i][23:16], rdv);
      `CHK(rdv, rows[i][7:0])
    end
    // detection follows the enable bit only
    fast_swap_signal = 1'b1;
    settle(3);
    `CHK(fast_swap_detected, 1'b0)
    pdv_host_model_inst.wr(8'h96, 8'h08);
    settle(3);
    `CHK(fast_swap_detected, 1'b1)
    // thresholds from the power role, then from each select code
    power_role_source = 1'b1;
    settle(3);
    `CHK({th_hi, th_lo}, 4'h5)
    power_role_source = 1'b0;
    settle(3);
    `CHK({th_hi, th_lo}, 4'h0)
    for (int c = 0; c < 4; c++)
    begin
      pdv_host_model_inst.wr(8'h96, 8'h04 | 8'(c));
      eh = (c == 3) ? 2'h0 : 2'(c);
      el = (c == 3) ? 2'h1 : 2'(c);
      settle(3);
      `CHK({th_hi, th_lo}, {eh, el})
    end
    // each receiver event reaches its own status bit
    for (int i = 0; i < 4; i++)
    begin
      rx_ev = 4'h1 << i;
      settle(3);
      pdv_host_model_inst.rd(8'h97, rdv);
      `CHK(rdv, {4'h0, rx_ev})
    end
    rx_ev = 4'h0;
    settle(3);
    pdv_host_model_inst.rd(8'h97, rdv);
    `CHK(rdv, 8'h00)
    // internal discharge unless disabled, every combination
    dreq = 2'h3;
    for (int d = 0; d < 4; d++)
    begin
      pdv_host_model_inst.wr(8'h98, 8'(d));
      settle(3);
      `CHK(dis_on, ~2'(d))
    end
    // shutdown and live state only while enabled
    overtemp_sensor = 1'b1;
    pdv_host_model_inst.wr(8'h99, 8'h00);
    settle(3);
    `CHK(overtemp_shutdown, 1'b0)
    pdv_host_model_inst.wr(8'h99, 8'hff);
    settle(3);
    `CHK(overtemp_shutdown, 1'b1)
    pdv_host_model_inst.rd(8'h99, rdv);
    `CHK(rdv, 8'h11)
    // low byte alone stays pending
    pdv_host_model_inst.wr(8'ha0, 8'h03);
    settle(3);
    `CHK(slow_timer_running, 1'b0)
    pdv_host_model_inst.wr(8'ha1, 8'h00);
    n = 0;
    while (slow_timer_expired !== 1'b1 && n < 200)
    begin
      settle(1);
      n++;
    end
    `CHK(n >= 3 * TICK - 2 && n <= 3 * TICK + 3, 1'b1)
    `CHK(slow_timer_running, 1'b0)
    pdv_host_model_inst.rd(8'ha0, rdv);
    `CHK(rdv, 8'h03)
    // high byte carries the upper bits of the count
    pdv_host_model_inst.wr(8'ha0, 8'h00);
    pdv_host_model_inst.wr(8'ha1, 8'h01);
    settle(300);
    `CHK({slow_timer_running, slow_timer_expired}, 2'h2)
    // software stops the timer by loading zero
    pdv_host_model_inst.wr(8'ha1, 8'h00);
    settle(3);
    `CHK(slow_timer_running, 1'b0)
    settle(1100);
    `CHK(slow_timer_expired, 1'b0)
    // reset in mid-run drops every control bit back to zero
    pdv_host_model_inst.wr(8'h96, 8'h0f);
    rst = 1'b1;
    settle(2);
    rst = 1'b0;
    pdv_host_model_inst.rd(8'h96, rdv);
    `CHK(rdv, 8'h00)
    `CHK(overtemp_shutdown, 1'b0)
    `CHK(dis_on, 2'h3)
    wrap_up();
  end
endmodule : pdv_bank_tb_top
